// [src/dsl_top.sv]
// Serial load interface of a 16-bit converter: shift, input register and latch
// Contract
// - Load low: latch follows each new word
// - Load high: latch holds its value
// - Load falling copies input register to latch
// - Word is sixteen bits in shift register
// - Chip select low frames and enables shifting
// - Sample data on rising serial clock
// - Short frames are not loaded; their bits stay in shift register
// - Long frames keep last sixteen bits
// - Mode high: readback input register on output
// - Readback then zeros; keep last sixteen
// - Mode low: chain bits out on falling
// - Chain mode stops shifting at select high
// - Chain mode loads on select rising edge
// - Words travel most significant bit first
`timescale 1ns/1ps
module dsl_top #(
  parameter int unsigned WORD_W = dsl_pkg::WORD_BITS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic serial_clk_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_i,
  input wire logic load_strobe_n_i,
  input wire logic readout_mode_select_i,
  output logic serial_data_o,
  output logic [WORD_W-1:0] input_word_o,
  output logic [WORD_W-1:0] latch_word_o,
  output logic latch_update_o
);
  localparam int unsigned CW = $clog2(WORD_W) + 2;

  // Edge of a synchronised level, found against its copy from the cycle before
  function automatic logic level_rose(input logic now_lvl, input logic was_lvl);
    return now_lvl && !was_lvl;
  endfunction : level_rose

  function automatic logic level_fell(input logic now_lvl, input logic was_lvl);
    return !now_lvl && was_lvl;
  endfunction : level_fell

  // Pin levels crossing into the reference clock domain
  logic [4:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic load_n_s;
  logic mode_s;

  wire [4:0] pins_async = {
    serial_clk_i,
    chip_select_n_i,
    serial_data_i,
    load_strobe_n_i,
    readout_mode_select_i
  };

  dsl_sync #(
    .WIDTH(5),
    .INIT(dsl_pkg::PIN_SYNC_RESET)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  assign {sclk_s, cs_n_s, sdi_s, load_n_s, mode_s} = pins_sync;

  logic sclk_d_ff;
  logic cs_n_d_ff;
  logic load_n_d_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] readback_ff;
  logic [CW-1:0] count_ff;
  logic [WORD_W-1:0] input_ff;
  logic [WORD_W-1:0] latch_ff;
  logic sdo_ff;
  logic update_ff;

  wire sclk_rise = level_rose(sclk_s, sclk_d_ff);
  wire sclk_fall = level_fell(sclk_s, sclk_d_ff);
  wire cs_fall = level_fell(cs_n_s, cs_n_d_ff);
  wire cs_rise = level_rose(cs_n_s, cs_n_d_ff);
  wire load_fall = level_fell(load_n_s, load_n_d_ff);
  wire in_frame = !cs_n_s;
  wire shift_en = in_frame && sclk_rise;
  wire [CW-1:0] full_count = CW'(WORD_W);
  wire count_sat = (count_ff >= full_count);
  wire frame_valid = count_sat;
  wire [WORD_W-1:0] shift_next = {shift_ff[WORD_W-2:0], sdi_s};
  wire stand_alone = mode_s;

  // Completed frames queue for the input register
  logic buf_in_ready;
  logic buf_out_valid;
  logic [WORD_W-1:0] buf_out_data;
  wire frame_push = cs_rise && frame_valid;

  dsl_buf #(
    .WIDTH(WORD_W),
    .DEPTH(dsl_pkg::BUF_DEPTH)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_valid_i(frame_push),
    .in_ready_o(buf_in_ready),
    .in_data_i(shift_ff),
    .out_valid_o(buf_out_valid),
    .out_ready_i(1'b1),
    .out_data_o(buf_out_data)
  );

  wire word_loaded = buf_out_valid;

  // Latch source: fresh word while load low, else the held input register
  wire latch_from_new = word_loaded && !load_n_s;
  wire latch_from_input = load_fall && !word_loaded;
  wire latch_take = latch_from_new || latch_from_input;
  wire [WORD_W-1:0] latch_src = latch_from_new ? buf_out_data : input_ff;

  // Readout bit for this serial clock
  // Past the first falling edge the copy shifts in the same cycle, so take the bit behind its top
  wire sdo_next_sa = (count_ff != '0) ? readback_ff[WORD_W-2] : readback_ff[WORD_W-1];
  wire sdo_next_dc = shift_ff[WORD_W-1];
  wire sdo_next = stand_alone ? sdo_next_sa : sdo_next_dc;

  // Next values of every register; the clocked blocks below only load them
  logic nxt_sclk_d;
  logic nxt_cs_n_d;
  logic nxt_load_n_d;
  logic [CW-1:0] nxt_count;
  logic [WORD_W-1:0] nxt_shift;
  logic [WORD_W-1:0] nxt_readback;
  logic nxt_sdo;
  logic [WORD_W-1:0] nxt_input;
  logic [WORD_W-1:0] nxt_latch;
  logic nxt_update;

  assign nxt_sclk_d = sclk_s;
  assign nxt_cs_n_d = cs_n_s;
  assign nxt_load_n_d = load_n_s;

  // Bit counter restarts at frame start and stops at one full word
  wire count_step = shift_en && !count_sat;
  wire [CW-1:0] count_inc = count_ff + CW'(1);
  assign nxt_count = cs_fall ? '0 : (count_step ? count_inc : count_ff);

  assign nxt_shift = shift_en ? shift_next : shift_ff;

  // Readback copy is loaded at frame start and drains zeros behind it
  wire readback_step = in_frame && sclk_fall && (count_ff != '0);
  wire [WORD_W-1:0] readback_shifted = {readback_ff[WORD_W-2:0], 1'b0};
  assign nxt_readback = cs_fall ? input_ff : (readback_step ? readback_shifted : readback_ff);

  // Output changes only at the select falling edge and on falling serial clock edges inside a frame
  wire sdo_load = in_frame && (cs_fall || sclk_fall);
  wire sdo_first = stand_alone ? input_ff[WORD_W-1] : shift_ff[WORD_W-1];
  assign nxt_sdo = sdo_load ? (cs_fall ? sdo_first : sdo_next) : sdo_ff;

  assign nxt_input = word_loaded ? buf_out_data : input_ff;
  assign nxt_latch = latch_take ? latch_src : latch_ff;
  assign nxt_update = latch_take;

  // Delayed levels start at the idle pin levels so that no false edge follows reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sclk_d_ff <= dsl_pkg::SCLK_IDLE;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cs_n_d_ff <= dsl_pkg::CS_N_IDLE;
    end else begin
      cs_n_d_ff <= nxt_cs_n_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      load_n_d_ff <= dsl_pkg::LOAD_N_IDLE;
    end else begin
      load_n_d_ff <= nxt_load_n_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count_ff <= CW'(dsl_pkg::BIT_COUNT_RESET);
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      shift_ff <= dsl_pkg::WORD_RESET;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      readback_ff <= dsl_pkg::WORD_RESET;
    end else begin
      readback_ff <= nxt_readback;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sdo_ff <= dsl_pkg::SDO_RESET;
    end else begin
      sdo_ff <= nxt_sdo;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      input_ff <= dsl_pkg::WORD_RESET;
    end else begin
      input_ff <= nxt_input;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      latch_ff <= dsl_pkg::LATCH_RESET;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      update_ff <= 1'b0;
    end else begin
      update_ff <= nxt_update;
    end
  end

  assign serial_data_o = sdo_ff;
  assign input_word_o = input_ff;
  assign latch_word_o = latch_ff;
  assign latch_update_o = update_ff;

  wire unused_ready = buf_in_ready;
endmodule : dsl_top

// [inc/dsl_pkg.sv]
// Shared constants for the converter serial load interface
package dsl_pkg;
  localparam int unsigned WORD_BITS = 16;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [5:0] BIT_COUNT_RESET = 6'h00;
  localparam logic [4:0] PIN_SYNC_RESET = 5'h1B;
  localparam logic SCLK_IDLE = 1'h1;
  localparam logic CS_N_IDLE = 1'h1;
  localparam logic LOAD_N_IDLE = 1'h1;
  localparam logic SDO_RESET = 1'h0;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned BUF_DEPTH = 2;
endpackage : dsl_pkg

// [src/dsl_sync.sv]
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module dsl_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : dsl_sync

// [src/dsl_buf.sv]
// Two-entry valid/ready buffer for completed words
`timescale 1ns/1ps
module dsl_buf #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW-1:0] wr_next = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
  wire [AW-1:0] rd_next = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;

  assign in_ready_o = (cnt_ff != (AW + 1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_next;
      if (pop) rd_ff <= rd_next;
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : dsl_buf

// [test/dsl_monitor.sv]
// Port checker for the serial load interface
`timescale 1ns/1ps
module dsl_monitor #(parameter int unsigned WORD_W = 16) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic chip_select_n_i,
  input wire logic load_strobe_n_i,
  input wire logic serial_data_o,
  input wire logic [WORD_W-1:0] input_word_o,
  input wire logic [WORD_W-1:0] latch_word_o,
  input wire logic latch_update_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_latch_source: assert property ($changed(latch_word_o) |-> latch_word_o == input_word_o)
    else $error("latch source");
  a_update_pulse: assert property ($changed(latch_word_o) |-> latch_update_o)
    else $error("update pulse");
  a_latch_hold: assert property (load_strobe_n_i [*8] |=> $stable(latch_word_o))
    else $error("latch hold");
  a_load_copy: assert property ($fell(load_strobe_n_i) ##1 (!load_strobe_n_i) [*6] |-> latch_word_o == input_word_o)
    else $error("load copy");
  a_load_follow: assert property ((!load_strobe_n_i) [*8] ##0 $changed(input_word_o) |-> ##[1:2] latch_word_o == input_word_o)
    else $error("load follow");
  a_input_frame: assert property ($changed(input_word_o) |-> $past(chip_select_n_i, 3))
    else $error("input frame");
  a_input_quiet: assert property (chip_select_n_i [*8] |=> $stable(input_word_o))
    else $error("input quiet");
  a_output_quiet: assert property (chip_select_n_i [*8] |=> $stable(serial_data_o))
    else $error("output quiet");
  c_update: cover property (latch_update_o);
  c_load_fall: cover property ($fell(load_strobe_n_i));
  c_frame_end: cover property ($rose(chip_select_n_i));
endmodule : dsl_monitor
bind dsl_top dsl_monitor #(.WORD_W(WORD_W)) i_mon (
  .ref_clk_i(ref_clk_i),
  .reset_i(reset_i),
  .chip_select_n_i(chip_select_n_i),
  .load_strobe_n_i(load_strobe_n_i),
  .serial_data_o(serial_data_o),
  .input_word_o(input_word_o),
  .latch_word_o(latch_word_o),
  .latch_update_o(latch_update_o)
);

// [test/dsl_host.sv]
// Serial master model framing words into the load interface
`timescale 1ns/1ps
module dsl_host (
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic send(input logic [47:0] w, input int n, output logic [47:0] rb);
    rb = '0;
    // Step off the reference clock edge so pin changes never race the sampling flops
    #1;
    cs_n_o = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = w[i];
      #100;
      sclk_o = 1'b1;
      rb = {rb[46:0], sdo_i};
      #100;
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask : send
  // Clock activity with the frame closed
  task automatic idle_clocks(input int n);
    #1;
    repeat (n) begin
      sclk_o = 1'b0;
      sdi_o = ~sdi_o;
      #100;
      sclk_o = 1'b1;
      #100;
    end
  endtask : idle_clocks
endmodule : dsl_host

// [test/test_dsl_top.sv]
// Self-checking bench for the serial load interface
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_dsl_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic load_n = 1'b0;
  logic mode = 1'b1;
  logic sclk, cs_n, sdi, sdo, upd;
  logic [15:0] in_w, lat_w;
  logic [47:0] rb;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n_upd = 0;
  dsl_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .serial_clk_i(sclk), .chip_select_n_i(cs_n),
    .serial_data_i(sdi), .load_strobe_n_i(load_n), .readout_mode_select_i(mode), .serial_data_o(sdo),
    .input_word_o(in_w), .latch_word_o(lat_w), .latch_update_o(upd));
  dsl_host i_host (.sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic complete_run();
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk_i) begin
    cyc++;
    if (upd === 1'b1) n_upd++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic drive(input logic ld, input logic md);
    @(posedge ref_clk_i);
    #1;
    load_n = ld;
    mode = md;
    repeat (20) @(posedge ref_clk_i);
  endtask : drive
  task automatic frame(input logic [47:0] w, input int n);
    i_host.send(w, n, rb);
    repeat (20) @(posedge ref_clk_i);
  endtask : frame
  task automatic t_direct();
    frame(48'hA5C3, 16);
    `CHK("input", 16'hA5C3, in_w)
    `CHK("latch", 16'hA5C3, lat_w)
    `CHK("readback", 16'h0000, rb[15:0])
  endtask : t_direct
  task automatic t_deferred();
    int n0;
    drive(1'b1, 1'b1);
    n0 = n_upd;
    frame(48'h1234, 16);
    `CHK("input", 16'h1234, in_w)
    `CHK("latch", 16'hA5C3, lat_w)
    `CHK("update count", n0, n_upd)
    `CHK("readback", 16'hA5C3, rb[15:0])
    drive(1'b0, 1'b1);
    `CHK("latch", 16'h1234, lat_w)
    `CHK("update count", n0 + 1, n_upd)
  endtask : t_deferred
  task automatic t_short_long();
    // Readback of a short frame is partial and not looked at
    frame(48'h3FF, 10);
    i_host.idle_clocks(20);
    repeat (20) @(posedge ref_clk_i);
    `CHK("input", 16'h1234, in_w)
    `CHK("latch", 16'h1234, lat_w)
    frame(48'h5BEEF, 20);
    `CHK("input", 16'hBEEF, in_w)
    `CHK("latch", 16'hBEEF, lat_w)
    `CHK("readback", 20'h12340, rb[19:0])
  endtask : t_short_long
  task automatic t_chain();
    drive(1'b0, 1'b0);
    frame(48'hCAFE0F0F, 32);
    `CHK("input", 16'h0F0F, in_w)
    `CHK("chain out", 16'hCAFE, rb[15:0])
    i_host.idle_clocks(8);
    frame(48'h7777, 16);
    `CHK("chain out", 16'h0F0F, rb[15:0])
    `CHK("input", 16'h7777, in_w)
  endtask : t_chain
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_direct();
    t_deferred();
    t_short_long();
    t_chain();
    complete_run();
  end
endmodule : test_dsl_top
